// [rtl/ssr_cfg.svh]
/*
 Constants for the status byte / service request block: bit positions,
 reset values, mode encodings and command codes.
 Assumes inclusion by bare name from the rtl folder.
*/
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

`define SSR_BIT_TIMEOUT 3'h0
`define SSR_BIT_BUS_ERROR 3'h1
`define SSR_BIT_MAV 3'h4
`define SSR_BIT_ESB 3'h5
`define SSR_BIT_MSS 3'h6
`define SSR_UNUSED_MASK 8'h8C
`define SSR_MASK_RESET 8'h00
`define SSR_ADDR_RESET 5'h01
`define SSR_ADDR_MIN 5'h01
`define SSR_ADDR_MAX 5'h1E
`define SSR_MODE_LOCAL 2'h0
`define SSR_MODE_REMOTE 2'h1
`define SSR_MODE_LLO 2'h2
`define SSR_CMD_NONE 3'h0
`define SSR_CMD_SET_MASK 3'h1
`define SSR_CMD_GET_MASK 3'h2
`define SSR_CMD_GET_STATUS 3'h3
`define SSR_CMD_SET_ADDR 3'h4
`define SSR_CMD_SET_MODE 3'h5
`define SSR_CMD_GET_MODE 3'h6

`endif

// [rtl/ssr_edge_flag.sv]
/*
 Sticky flag set on a rising edge of a level and cleared by either the
 level falling or an external clear. Assumes one clock, sync reset.
*/
`timescale 1ns/100ps
module ssr_edge_flag (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic level_in,
	input wire logic clear_in,
	output logic flag_out
);
	logic level_reg;
	logic flag_reg;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			level_reg <= 1'b0;
		else
			level_reg <= level_in;
	end

	// Set wins over clear so a fresh edge during a poll is not lost
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			flag_reg <= 1'b0;
		else if (level_in && !level_reg)
			flag_reg <= 1'b1;
		else if (!level_in || clear_in)
			flag_reg <= 1'b0;
	end

	assign flag_out = flag_reg;
endmodule // ssr_edge_flag

// [rtl/ssr_pkg.sv]
/*
 Types for the status byte / service request block.
 Assumes ssr_cfg.svh supplies the numeric constants.
*/
package ssr_pkg;
	typedef enum logic [1:0] {
		SSR_ST_IDLE = 2'h0,
		SSR_ST_EXEC = 2'h1,
		SSR_ST_ANSWER = 2'h3
	} ssr_state_type;

	typedef struct packed {
		logic [2:0] code;
		logic [7:0] value;
	} ssr_cmd_type;

	typedef struct packed {
		logic valid;
		logic [7:0] value;
	} ssr_resp_type;
endpackage

// [rtl/ssr_status.sv]
/*
 Status byte, service request enable mask, remote/local state and local
 bus slave select of a remote-controlled instrument. Commands arrive as
 decoded single-cycle strobes from the command parser; answers leave as a
 registered value with a one-cycle valid.
 Assumes the parser keeps values in range and zeroes unused mask bits.
*/
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module ssr_status (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CMD_VALID_IN,
	input wire logic [2:0] CMD_CODE_IN,
	input wire logic [7:0] CMD_VALUE_IN,
	input wire logic [7:0] EVENT_STATUS_IN,
	input wire logic [7:0] EVENT_ENABLE_IN,
	input wire logic OUTQ_NONEMPTY_IN,
	input wire logic LOCAL_BUS_ERROR_FLAG_IN,
	input wire logic LOCAL_BUS_TIMEOUT_FLAG_IN,
	input wire logic SERIAL_POLL_DONE_IN,
	input wire logic PARALLEL_BUS_IN,
	input wire logic LOCAL_KEY_IN,
	output logic CMD_READY_OUT,
	output logic RESP_VALID_OUT,
	output logic [7:0] RESP_VALUE_OUT,
	output logic [7:0] STATUS_BYTE_OUT,
	output logic [7:0] SERIAL_POLL_BYTE_OUT,
	output logic SERVICE_REQUEST_OUT,
	output logic [1:0] REMOTE_MODE_OUT,
	output logic [4:0] SLAVE_SELECT_OUT
);
	ssr_pkg::ssr_state_type state_reg;
	ssr_pkg::ssr_state_type state_next;
	ssr_pkg::ssr_cmd_type cmd_reg;
	ssr_pkg::ssr_resp_type resp_reg;
	ssr_pkg::ssr_resp_type resp_next;
	logic [7:0] mask_reg;
	logic [1:0] mode_reg;
	logic [4:0] addr_reg;
	logic [7:0] source_bits;
	logic [7:0] status_byte;
	logic mss;
	logic rqs;
	logic esb;
	logic mode_set;
	logic mode_query_local;

	////////////////////////////////////////////////////////////////////
	// Status byte assembly

	assign esb = |(EVENT_STATUS_IN & EVENT_ENABLE_IN);

	always_comb begin
		source_bits = 8'h00;
		source_bits[`SSR_BIT_MAV] = OUTQ_NONEMPTY_IN;
		source_bits[`SSR_BIT_ESB] = esb;
		source_bits[`SSR_BIT_BUS_ERROR] = LOCAL_BUS_ERROR_FLAG_IN;
		source_bits[`SSR_BIT_TIMEOUT] = LOCAL_BUS_TIMEOUT_FLAG_IN;
	end

	// Mask zero blocks, one passes; bit 6 excluded by construction
	assign mss = |(source_bits & mask_reg);

	always_comb begin
		status_byte = source_bits;
		status_byte[`SSR_BIT_MSS] = mss;
	end

	ssr_edge_flag u_rqs (
		.clk_in(CLK_IN),
		.rst_b_in(RST_B_IN),
		.level_in(mss),
		.clear_in(SERIAL_POLL_DONE_IN),
		.flag_out(rqs)
	);

	////////////////////////////////////////////////////////////////////
	// Command sequencer

	assign CMD_READY_OUT = (state_reg == ssr_pkg::SSR_ST_IDLE);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ssr_pkg::SSR_ST_IDLE: begin
				if (CMD_VALID_IN)
					state_next = ssr_pkg::SSR_ST_EXEC;
			end
			ssr_pkg::SSR_ST_EXEC: begin
				state_next = ssr_pkg::SSR_ST_ANSWER;
			end
			ssr_pkg::SSR_ST_ANSWER: begin
				state_next = ssr_pkg::SSR_ST_IDLE;
			end
			default: begin
				state_next = ssr_pkg::SSR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN)
			state_reg <= ssr_pkg::SSR_ST_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			cmd_reg <= '0;
		end else if (CMD_VALID_IN && CMD_READY_OUT) begin
			cmd_reg.code <= CMD_CODE_IN;
			cmd_reg.value <= CMD_VALUE_IN;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Enable mask

	// Whole byte stored as given; unused bits cleared by the controller
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN)
			mask_reg <= `SSR_MASK_RESET;
		else if (state_reg == ssr_pkg::SSR_ST_EXEC &&
			cmd_reg.code == `SSR_CMD_SET_MASK)
			mask_reg <= cmd_reg.value;
	end

	////////////////////////////////////////////////////////////////////
	// Slave select

	// Out-of-range values are dropped silently; no slave check is made
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN)
			addr_reg <= `SSR_ADDR_RESET;
		else if (state_reg == ssr_pkg::SSR_ST_EXEC &&
			cmd_reg.code == `SSR_CMD_SET_ADDR &&
			cmd_reg.value[7:5] == 3'h0 &&
			cmd_reg.value[4:0] >= `SSR_ADDR_MIN &&
			cmd_reg.value[4:0] <= `SSR_ADDR_MAX)
			addr_reg <= cmd_reg.value[4:0];
	end

	////////////////////////////////////////////////////////////////////
	// Remote/local state

	// Key press is a one-cycle pulse, so it is honoured while any command
	// executes; only a mode set with a legal mode in the same cycle overrides it
	assign mode_set = state_reg == ssr_pkg::SSR_ST_EXEC &&
		cmd_reg.code == `SSR_CMD_SET_MODE &&
		cmd_reg.value <= {6'h00, `SSR_MODE_LLO};
	assign mode_query_local = state_reg == ssr_pkg::SSR_ST_EXEC &&
		cmd_reg.code == `SSR_CMD_GET_MODE &&
		mode_reg == `SSR_MODE_LOCAL;

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			mode_reg <= `SSR_MODE_LOCAL;
		end else if (mode_set) begin
			mode_reg <= cmd_reg.value[1:0];
		end else if (mode_query_local) begin
			mode_reg <= `SSR_MODE_REMOTE;
		end else if (LOCAL_KEY_IN && mode_reg == `SSR_MODE_REMOTE) begin
			// Lockout state is not matched, so the key is ignored there
			mode_reg <= `SSR_MODE_LOCAL;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Answers

	always_comb begin
		resp_next.valid = 1'b0;
		resp_next.value = 8'h00;
		if (state_reg == ssr_pkg::SSR_ST_EXEC) begin
			case (cmd_reg.code)
				`SSR_CMD_GET_MASK: begin
					resp_next.valid = 1'b1;
					resp_next.value = mask_reg;
				end
				`SSR_CMD_GET_STATUS: begin
					resp_next.valid = 1'b1;
					// Only enabled sources plus summary; nothing cleared
					resp_next.value = (status_byte & mask_reg) |
						{1'b0, mss, 6'h00};
				end
				`SSR_CMD_GET_MODE: begin
					resp_next.valid = 1'b1;
					if (mode_reg == `SSR_MODE_LOCAL)
						resp_next.value = {6'h00, `SSR_MODE_REMOTE};
					else
						resp_next.value = {6'h00, mode_reg};
				end
				default: begin
					resp_next.valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN)
			resp_reg <= '0;
		else
			resp_reg <= resp_next;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign RESP_VALID_OUT = resp_reg.valid;
	assign RESP_VALUE_OUT = resp_reg.value;
	assign STATUS_BYTE_OUT = status_byte;
	assign SERIAL_POLL_BYTE_OUT = {1'b0, rqs, source_bits[5:0]};
	// Other remote interfaces have no request line to drive
	assign SERVICE_REQUEST_OUT = rqs & PARALLEL_BUS_IN;
	assign REMOTE_MODE_OUT = mode_reg;
	assign SLAVE_SELECT_OUT = addr_reg;

	////////////////////////////////////////////////////////////////////
	// Assertions

	a_mask_reset_zero: assert property (@(posedge CLK_IN)
		!RST_B_IN |=> mask_reg == 8'h00)
		else $error("mask not zero after reset");
	a_addr_in_range: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		addr_reg >= 5'h01 && addr_reg <= 5'h1E)
		else $error("slave select out of range");
	a_mss_summary: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		STATUS_BYTE_OUT[6] == |(STATUS_BYTE_OUT[5:0] & mask_reg[5:0]))
		else $error("summary bit wrong");
	a_rqs_on_rise: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		$rose(mss) |=> rqs || !mss)
		else $error("request not set on summary rise");
	a_rqs_clears: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		(!mss || (SERIAL_POLL_DONE_IN && $past(mss))) && !$rose(mss)
		|=> !rqs || $rose(mss))
		else $error("request flag not cleared");
	a_unused_zero: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		(STATUS_BYTE_OUT & 8'h8C) == 8'h00)
		else $error("unused status bits set");
	a_lockout_holds: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		mode_reg == 2'h2 && state_reg != ssr_pkg::SSR_ST_EXEC
		|=> mode_reg == 2'h2)
		else $error("lockout left without command");
	a_mode_query: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		state_reg == ssr_pkg::SSR_ST_EXEC &&
		cmd_reg.code == 3'h6 && mode_reg == 2'h0
		|=> RESP_VALID_OUT && RESP_VALUE_OUT == 8'h01 && mode_reg == 2'h1)
		else $error("mode query did not enter remote");
	a_mask_write: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		CMD_VALID_IN && CMD_READY_OUT && CMD_CODE_IN == 3'h1
		##2 1 |-> mask_reg == $past(CMD_VALUE_IN, 2))
		else $error("mask write lost");
	a_srq_parallel: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		!PARALLEL_BUS_IN |-> !SERVICE_REQUEST_OUT)
		else $error("request off parallel bus");
	a_status_masked: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		state_reg == ssr_pkg::SSR_ST_EXEC && cmd_reg.code == 3'h3
		|=> (RESP_VALUE_OUT & ~(mask_reg | 8'h40)) == 8'h00)
		else $error("status answer shows disabled bits");
	a_avail_bit: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		STATUS_BYTE_OUT[4] == OUTQ_NONEMPTY_IN)
		else $error("message available bit wrong");
	a_event_bit: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		STATUS_BYTE_OUT[5] == |(EVENT_STATUS_IN & EVENT_ENABLE_IN))
		else $error("event summary bit wrong");
	a_bus_flags: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		STATUS_BYTE_OUT[1:0] ==
		{LOCAL_BUS_ERROR_FLAG_IN, LOCAL_BUS_TIMEOUT_FLAG_IN})
		else $error("local bus status bits wrong");
	a_mode_legal: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		REMOTE_MODE_OUT != 2'h3)
		else $error("mode code out of range");
	a_addr_reset: assert property (@(posedge CLK_IN)
		!RST_B_IN |=> SLAVE_SELECT_OUT == 5'h01)
		else $error("slave select not one after reset");
	a_key_to_local: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		LOCAL_KEY_IN && mode_reg == 2'h1 && !mode_set && !mode_query_local
		|=> mode_reg == 2'h0)
		else $error("local key did not leave remote");
	a_resp_single: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		RESP_VALID_OUT |=> !RESP_VALID_OUT)
		else $error("answer valid longer than one cycle");
	a_resp_quiet: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		!RESP_VALID_OUT |-> RESP_VALUE_OUT == 8'h00)
		else $error("answer value without valid");
	a_query_keeps: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		state_reg == ssr_pkg::SSR_ST_EXEC && cmd_reg.code == 3'h3
		|=> $stable(mask_reg) && $stable(addr_reg))
		else $error("status query changed state");
	a_srq_follows: assert property (@(posedge CLK_IN)
		disable iff (!RST_B_IN)
		PARALLEL_BUS_IN |-> SERVICE_REQUEST_OUT == SERIAL_POLL_BYTE_OUT[6])
		else $error("request line differs from flag");

	c_srq_raised: cover property (@(posedge CLK_IN) $rose(SERVICE_REQUEST_OUT));
	c_poll_clear: cover property (@(posedge CLK_IN)
		rqs && SERIAL_POLL_DONE_IN ##1 !rqs);
	c_lockout: cover property (@(posedge CLK_IN) mode_reg == 2'h2);
	c_addr_set: cover property (@(posedge CLK_IN) addr_reg == 5'h1E);
	c_mode_query: cover property (@(posedge CLK_IN) mode_query_local);
endmodule // ssr_status

// [tb/ssr_ctl_model.sv]
/*
 Remote controller model: issues one command at a time, collects answer.
 Assumes the block's command handshake on one clock.
*/
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module ssr_ctl_model (
	input wire logic clk_in,
	input wire logic ready_in,
	input wire logic resp_valid_in,
	input wire logic [7:0] resp_value_in,
	output logic valid_out,
	output ssr_pkg::ssr_cmd_type cmd_out
);
	initial begin
		valid_out = 1'b0;
		cmd_out = '0;
	end
	// Ready only moves on rising edges, so it is read at the falling edge
	// before the edge that takes the command; a missing answer stays unknown
	task automatic send(input logic [2:0] code, input logic [7:0] value,
		output logic [7:0] resp);
		logic [7:0] v;
		int n;
		v = value;
		n = 0;
		if (code == `SSR_CMD_SET_MASK) begin
			v = v & ~`SSR_UNUSED_MASK;
		end
		resp = 8'hXX;
		@(posedge clk_in);
		valid_out <= 1'b1;
		cmd_out <= '{code: code, value: v};
		@(negedge clk_in);
		while (ready_in !== 1'b1 && n < 8) begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
		valid_out <= 1'b0;
		// Released lines show garbage, never the last value
		cmd_out <= '{code: ~code, value: ~v};
		repeat (4) begin
			@(negedge clk_in);
			if (resp_valid_in === 1'b1) begin
				resp = resp_value_in;
			end
		end
	endtask
endmodule // ssr_ctl_model

// [tb/tb_top.sv]
/*
 Self-checking bench for the status byte block.
 Assumes ssr_ctl_model as the remote controller.
*/
`timescale 1ns/100ps
`include "ssr_cfg.svh"
module tb_top;
	logic clk, rst_b, outq, bus_err, bus_tout, poll, par, key, cvalid;
	logic ready, rv, srq;
	logic [7:0] evs, eve, rval, stat_byte, spb, r;
	logic [1:0] mode;
	logic [4:0] slave;
	ssr_pkg::ssr_cmd_type cmd;
	int n_fail = 0;
	int checked = 0;
	ssr_status i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .CMD_VALID_IN(cvalid),
		.CMD_CODE_IN(cmd.code), .CMD_VALUE_IN(cmd.value),
		.EVENT_STATUS_IN(evs), .EVENT_ENABLE_IN(eve), .OUTQ_NONEMPTY_IN(outq),
		.LOCAL_BUS_ERROR_FLAG_IN(bus_err),
		.LOCAL_BUS_TIMEOUT_FLAG_IN(bus_tout),
		.SERIAL_POLL_DONE_IN(poll), .PARALLEL_BUS_IN(par),
		.LOCAL_KEY_IN(key), .CMD_READY_OUT(ready), .RESP_VALID_OUT(rv),
		.RESP_VALUE_OUT(rval), .STATUS_BYTE_OUT(stat_byte),
		.SERIAL_POLL_BYTE_OUT(spb), .SERVICE_REQUEST_OUT(srq),
		.REMOTE_MODE_OUT(mode), .SLAVE_SELECT_OUT(slave));
	ssr_ctl_model i_ctl (.clk_in(clk), .ready_in(ready), .resp_valid_in(rv),
		.resp_value_in(rval), .valid_out(cvalid), .cmd_out(cmd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wait2;
		repeat (2) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_mask;
		i_ctl.send(`SSR_CMD_SET_MASK, 8'h30, r);
		i_ctl.send(`SSR_CMD_GET_MASK, 8'h00, r);
		chk("mask", 8'h30, r);
		i_ctl.send(`SSR_CMD_SET_MASK, 8'hFF, r);
		i_ctl.send(`SSR_CMD_GET_MASK, 8'h00, r);
		chk("mask all", 8'h73, r);
		$display("test mask done");
	endtask
	task automatic t_status;
		i_ctl.send(`SSR_CMD_SET_MASK, 8'h30, r);
		@(posedge clk);
		bus_err <= 1'b1;
		bus_tout <= 1'b1;
		par <= 1'b1;
		wait2;
		chk("local bus bits", 8'h03, stat_byte);
		chk("blocked", 8'h00, {7'h0, srq});
		@(posedge clk);
		outq <= 1'b1;
		wait2;
		chk("queue", 8'h53, stat_byte);
		chk("poll byte", 8'h40, spb & 8'h40);
		chk("request", 8'h01, {7'h0, srq});
		i_ctl.send(`SSR_CMD_GET_STATUS, 8'h00, r);
		chk("query", 8'h50, r);
		chk("kept", 8'h53, stat_byte);
		chk("flag kept", 8'h40, spb & 8'h40);
		@(posedge clk);
		par <= 1'b0;
		@(negedge clk);
		chk("parallel only", 8'h00, {7'h0, srq});
		@(posedge clk);
		poll <= 1'b1;
		par <= 1'b1;
		@(posedge clk);
		poll <= 1'b0;
		@(negedge clk);
		chk("polled", 8'h00, spb & 8'h40);
		// Summary stays high across the swap, so no new request
		@(posedge clk);
		outq <= 1'b0;
		evs <= 8'h10;
		eve <= 8'h10;
		wait2;
		chk("event", 8'h63, stat_byte);
		chk("no rise", 8'h00, spb & 8'h40);
		@(posedge clk);
		evs <= 8'h00;
		@(posedge clk);
		outq <= 1'b1;
		wait2;
		chk("rise again", 8'h40, spb & 8'h40);
		@(posedge clk);
		outq <= 1'b0;
		wait2;
		chk("summary low", 8'h00, spb & 8'h40);
		chk("unused", 8'h00, stat_byte & 8'h8C);
		i_ctl.send(`SSR_CMD_SET_MASK, 8'h01, r);
		chk("timeout source", 8'h43, stat_byte);
		@(posedge clk);
		bus_err <= 1'b0;
		bus_tout <= 1'b0;
		$display("test status done");
	endtask
	task automatic t_mode;
		i_ctl.send(`SSR_CMD_GET_MODE, 8'h00, r);
		chk("mode query", 8'h01, r);
		chk("entered", 8'h01, {6'h0, mode});
		i_ctl.send(`SSR_CMD_SET_MODE, 8'h02, r);
		@(posedge clk);
		key <= 1'b1;
		@(posedge clk);
		key <= 1'b0;
		wait2;
		chk("lockout", 8'h02, {6'h0, mode});
		i_ctl.send(`SSR_CMD_SET_MODE, 8'h01, r);
		@(posedge clk);
		key <= 1'b1;
		@(posedge clk);
		key <= 1'b0;
		wait2;
		chk("to local", 8'h00, {6'h0, mode});
		$display("test mode done");
	endtask
	task automatic t_addr;
		i_ctl.send(`SSR_CMD_SET_ADDR, 8'h1E, r);
		chk("addr top", 8'h1E, {3'h0, slave});
		i_ctl.send(`SSR_CMD_SET_ADDR, 8'h19, r);
		chk("absent unit", 8'h19, {3'h0, slave});
		i_ctl.send(`SSR_CMD_SET_ADDR, 8'h01, r);
		chk("restored", 8'h01, {3'h0, slave});
		$display("test addr done");
	endtask
	task automatic t_power;
		i_ctl.send(`SSR_CMD_SET_MASK, 8'h30, r);
		i_ctl.send(`SSR_CMD_SET_ADDR, 8'h03, r);
		i_ctl.send(`SSR_CMD_SET_MODE, 8'h02, r);
		// State must differ from the reset values before the reset counts
		chk("slave set", 8'h03, {3'h0, slave});
		chk("lockout set", 8'h02, {6'h0, mode});
		i_ctl.send(`SSR_CMD_GET_MASK, 8'h00, r);
		chk("mask set", 8'h30, r);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("mode", 8'h00, {6'h0, mode});
		chk("slave", 8'h01, {3'h0, slave});
		i_ctl.send(`SSR_CMD_GET_MASK, 8'h00, r);
		chk("mask", 8'h00, r);
		$display("test power done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		results;
	end
	initial begin
		{rst_b, outq, bus_err, bus_tout, poll, par, key} = '0;
		evs = 8'h00;
		eve = 8'h00;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_mask;
		t_status;
		t_mode;
		t_addr;
		t_power;
		results;
	end
endmodule // tb_top
